//--- verilog/pll_div_consts.svh
`ifndef PLL_DIV_CONSTS_SVH
`define PLL_DIV_CONSTS_SVH

// register offsets on the serial control port
`define LOOP_PUMP_CONTROL_ADDR 10'h010
`define REF_DIVIDER_LOW_ADDR 10'h011
`define REF_DIVIDER_HIGH_ADDR 10'h012
`define SWALLOW_COUNT_ADDR 10'h013
`define MAIN_COUNT_LOW_ADDR 10'h014
`define MAIN_COUNT_HIGH_ADDR 10'h015

// reset values
`define LOOP_PUMP_CONTROL_RST 8'h7d
`define REF_DIVIDER_LOW_RST 8'h01
`define REF_DIVIDER_HIGH_RST 8'h00
`define SWALLOW_COUNT_RST 8'h00
`define MAIN_COUNT_LOW_RST 8'h03
`define MAIN_COUNT_HIGH_RST 8'h00

// field positions inside loop_pump_control
`define PUMP_DRIVE_SELECT_MSB 3
`define PUMP_DRIVE_SELECT_LSB 2
`define LOOP_POWER_DOWN_MSB 1
`define LOOP_POWER_DOWN_LSB 0
`define PUMP_CURRENT_MSB 6
`define PUMP_CURRENT_LSB 4
`define PFD_POLARITY_BIT 7

// top stored bit of the partly used registers
`define REF_DIVIDER_HIGH_MSB 5
`define SWALLOW_COUNT_MSB 5
`define MAIN_COUNT_HIGH_MSB 4

// masks of writable bits, unused bits read as zero
`define REF_DIVIDER_HIGH_MASK 8'h3f
`define SWALLOW_COUNT_MASK 8'h3f
`define MAIN_COUNT_HIGH_MASK 8'h1f

`endif

//--- verilog/pll_div_pkg.sv
package pll_div_pkg;

  // charge pump drive modes
  typedef enum logic [1:0] {
    PUMP_HIGH_Z = 2'h0,
    PUMP_FORCE_SOURCE = 2'h1,
    PUMP_FORCE_SINK = 2'h2,
    PUMP_NORMAL = 2'h3
  } pump_drive_e;

  // loop power-down modes
  typedef enum logic [1:0] {
    LOOP_RUN = 2'h0,
    LOOP_ASYNC_PD = 2'h1,
    LOOP_UNUSED_PD = 2'h2,
    LOOP_SYNC_PD = 2'h3
  } loop_pd_e;

  typedef logic [7:0] byte_t;

  // whole state of the register slice
  typedef struct packed {
    byte_t loop_pump_control;
    byte_t ref_divider_low;
    byte_t ref_divider_high;
    byte_t swallow_count;
    byte_t main_count_low;
    byte_t main_count_high;
    byte_t rd_data;
  } regs_s;

endpackage

//--- verilog/pll_divider_config_regs.sv
`timescale 1ns/1ps
`include "pll_div_consts.svh"

// Summary of operation
// RQ1: pump_drive_select 00 high-z, 01 source, 10 sink, 11 normal (default).
// RQ2: loop power-down 00 run, 01 async down (default), 10 unused, 11 sync down.
// RQ3: reference divider is 14 bits, low byte at 0x011, reset 0x01.
// RQ4: reference divider upper six bits at 0x012 [5:0], default zero, [7:6] unused.
// RQ5: swallow counter six bits at 0x013 [5:0], default 0x00, top bits unused.
// RQ6: main counter low byte at 0x014, reset 0x03.
// RQ7: main counter upper five bits at 0x015 [4:0], default zero.
module pll_divider_config_regs
  import pll_div_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic addr_hit,
  output logic [1:0] pump_drive_select,
  output logic pump_high_z,
  output logic pump_force_source,
  output logic pump_force_sink,
  output logic pump_normal,
  output logic [1:0] loop_power_down,
  output logic loop_running,
  output logic loop_async_pd,
  output logic loop_sync_pd,
  output logic loop_pd_unused,
  output logic [2:0] pump_current_code,
  output logic pfd_negative,
  output logic [13:0] ref_divider,
  output logic [5:0] swallow_count,
  output logic [12:0] main_count
);

  regs_s state_reg;
  regs_s state_next;

  // address match, used for both write decode and read select
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [9:0] offset);
    addr_is = (a == ADDR_W'(offset));
  endfunction

  // pump mode decode, shared by the output flags
  function automatic logic pump_is(input logic [1:0] code, input pump_drive_e mode);
    pump_is = (code == mode);
  endfunction

  // loop power-down decode
  function automatic logic pd_is(input logic [1:0] code, input loop_pd_e mode);
    pd_is = (code == mode);
  endfunction

  // keeps only the bits a register really stores, so unused bits read zero
  function automatic byte_t keep_bits(input byte_t data, input byte_t mask);
    keep_bits = data & mask;
  endfunction

  // offsets of the slice in struct order, control byte first
  localparam int NUM_REGS = 6;
  localparam logic [9:0] REG_OFFSET [NUM_REGS] = '{
    `LOOP_PUMP_CONTROL_ADDR,
    `REF_DIVIDER_LOW_ADDR,
    `REF_DIVIDER_HIGH_ADDR,
    `SWALLOW_COUNT_ADDR,
    `MAIN_COUNT_LOW_ADDR,
    `MAIN_COUNT_HIGH_ADDR
  };

  logic [NUM_REGS-1:0] sel;
  logic sel_ctrl;
  logic sel_ref_lo;
  logic sel_ref_hi;
  logic sel_swallow;
  logic sel_main_lo;
  logic sel_main_hi;

  // one comparator per register, all fed from the same address
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_sel
      assign sel[i] = addr_is(addr, REG_OFFSET[i]);
    end
  endgenerate

  // named selects keep the next-state logic readable
  assign sel_ctrl = sel[0];
  assign sel_ref_lo = sel[1];
  assign sel_ref_hi = sel[2];
  assign sel_swallow = sel[3];
  assign sel_main_lo = sel[4];
  assign sel_main_hi = sel[5];

  // any other address belongs to another slice of the map
  assign addr_hit = |sel;

  // next-state logic: writes and read capture
  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      // control byte keeps all eight bits, pfd and current included
      if (sel_ctrl) begin
        state_next.loop_pump_control = wr_data; // RQ1 RQ2
      end
      // a divider word changes byte by byte, so it may pass odd values
      if (sel_ref_lo) begin
        state_next.ref_divider_low = wr_data; // RQ3
      end
      if (sel_ref_hi) begin
        // unused upper bits never store, so they always read zero
        state_next.ref_divider_high = keep_bits(wr_data, `REF_DIVIDER_HIGH_MASK); // RQ4
      end
      // swallow counter is six bits wide
      if (sel_swallow) begin
        state_next.swallow_count = keep_bits(wr_data, `SWALLOW_COUNT_MASK); // RQ5
      end
      // main counter low byte, upper bits live in the next register
      if (sel_main_lo) begin
        state_next.main_count_low = wr_data; // RQ6
      end
      // only five bits above the low byte make up the 13-bit counter
      if (sel_main_hi) begin
        state_next.main_count_high = keep_bits(wr_data, `MAIN_COUNT_HIGH_MASK); // RQ7
      end
    end
    // read data shows the stored value before any same-cycle write
    if (rd_en) begin
      unique case (1'b1)
        sel_ctrl: state_next.rd_data = state_reg.loop_pump_control;
        sel_ref_lo: state_next.rd_data = state_reg.ref_divider_low;
        sel_ref_hi: state_next.rd_data = state_reg.ref_divider_high;
        sel_swallow: state_next.rd_data = state_reg.swallow_count;
        sel_main_lo: state_next.rd_data = state_reg.main_count_low;
        sel_main_hi: state_next.rd_data = state_reg.main_count_high;
        default: state_next.rd_data = 8'h00; // unmapped reads give zero
      endcase
    end
  end

  // state register with clock enable; reset values are the defaults
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.loop_pump_control <= `LOOP_PUMP_CONTROL_RST; // RQ1 RQ2
      state_reg.ref_divider_low <= `REF_DIVIDER_LOW_RST; // RQ3
      state_reg.ref_divider_high <= `REF_DIVIDER_HIGH_RST; // RQ4
      state_reg.swallow_count <= `SWALLOW_COUNT_RST; // RQ5
      state_reg.main_count_low <= `MAIN_COUNT_LOW_RST; // RQ6
      state_reg.main_count_high <= `MAIN_COUNT_HIGH_RST; // RQ7
      state_reg.rd_data <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;

  // charge pump mode field and its decode
  assign pump_drive_select = state_reg.loop_pump_control[`PUMP_DRIVE_SELECT_MSB:
                                                         `PUMP_DRIVE_SELECT_LSB];
  assign pump_high_z = pump_is(pump_drive_select, PUMP_HIGH_Z); // RQ1
  assign pump_force_source = pump_is(pump_drive_select, PUMP_FORCE_SOURCE); // RQ1
  assign pump_force_sink = pump_is(pump_drive_select, PUMP_FORCE_SINK); // RQ1
  assign pump_normal = pump_is(pump_drive_select, PUMP_NORMAL); // RQ1

  // loop power-down field; only code 00 lets the loop lock
  assign loop_power_down = state_reg.loop_pump_control[`LOOP_POWER_DOWN_MSB:
                                                       `LOOP_POWER_DOWN_LSB];
  assign loop_running = pd_is(loop_power_down, LOOP_RUN); // RQ2
  assign loop_async_pd = pd_is(loop_power_down, LOOP_ASYNC_PD); // RQ2
  assign loop_sync_pd = pd_is(loop_power_down, LOOP_SYNC_PD); // RQ2
  // the unused code is flagged, the loop is not treated as running
  assign loop_pd_unused = pd_is(loop_power_down, LOOP_UNUSED_PD); // RQ2

  // neighbouring fields of the same byte, passed through as stored
  assign pump_current_code = state_reg.loop_pump_control[`PUMP_CURRENT_MSB:
                                                         `PUMP_CURRENT_LSB];
  assign pfd_negative = state_reg.loop_pump_control[`PFD_POLARITY_BIT];

  // divider words assembled from their byte registers
  assign ref_divider = {state_reg.ref_divider_high[`REF_DIVIDER_HIGH_MSB:0],
                        state_reg.ref_divider_low}; // RQ3 RQ4
  assign swallow_count = state_reg.swallow_count[`SWALLOW_COUNT_MSB:0]; // RQ5
  assign main_count = {state_reg.main_count_high[`MAIN_COUNT_HIGH_MSB:0],
                       state_reg.main_count_low}; // RQ6 RQ7

endmodule

//--- bench/pll_div_props.sv
`timescale 1ns/1ps
// write-to-output relations and divider reset defaults of the config slice, port level only
module pll_div_props #(
  parameter int ADDR_W = 10
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic pump_high_z,
  input wire logic pump_force_source,
  input wire logic pump_force_sink,
  input wire logic pump_normal,
  input wire logic loop_running,
  input wire logic loop_async_pd,
  input wire logic loop_pd_unused,
  input wire logic loop_sync_pd,
  input wire logic [13:0] ref_divider,
  input wire logic [5:0] swallow_count,
  input wire logic [12:0] main_count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] wa;
  logic [3:0] pump_oh, pd_oh;
  // ff marks no write; offsets above 0xff never alias into the slice
  assign wa = (ce && wr_en && addr < 10'h100) ? addr[7:0] : 8'hff;
  assign pump_oh = {pump_high_z, pump_force_source, pump_force_sink, pump_normal};
  assign pd_oh = {loop_running, loop_async_pd, loop_pd_unused, loop_sync_pd};
  pump_dec_a: assert property (wa == 8'h10 |=> pump_oh == 4'h8 >> $past(wr_data[3:2]))
    else $error("pump decode wrong");
  pd_dec_a: assert property (wa == 8'h10 |=> pd_oh == 4'h8 >> $past(wr_data[1:0]))
    else $error("power-down decode wrong");
  ref_low_a: assert property (wa == 8'h11 |=> ref_divider[7:0] == $past(wr_data))
    else $error("ref low byte wrong");
  ref_high_a: assert property (wa == 8'h12 |=> ref_divider[13:8] == $past(wr_data[5:0]))
    else $error("ref high bits wrong");
  swallow_store_a: assert property (wa == 8'h13 |=> swallow_count == $past(wr_data[5:0]))
    else $error("swallow count wrong");
  main_low_a: assert property (wa == 8'h14 |=> main_count[7:0] == $past(wr_data))
    else $error("main low byte wrong");
  main_high_a: assert property (wa == 8'h15 |=> main_count[12:8] == $past(wr_data[4:0]))
    else $error("main high bits wrong");
  rst_div_a: assert property ($rose(rstn) |-> ref_divider == 14'h1 && main_count == 13'h3)
    else $error("divider defaults wrong");
endmodule

bind pll_divider_config_regs pll_div_props #(.ADDR_W(ADDR_W)) u_props (.*);

//--- bench/host_model.sv
`timescale 1ns/1ps
// host on the control port: one strobe per access, idle lines scrambled
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] rd_data,
  input wire logic addr_hit,
  output logic ce,
  output logic wr_en,
  output logic rd_en,
  output logic [9:0] addr,
  output logic [7:0] wr_data
);
  // address match seen while the last request stood
  logic hit;
  initial {ce, wr_en, rd_en, addr, wr_data, hit} = '0;
  // launch just after an edge, take the answer after the next one
  task automatic xfer(input logic w, c, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge ref_clk);
    #1 {ce, wr_en, rd_en, addr, wr_data} = {c, w, !w, a, d};
    #1 hit = addr_hit;
    @(posedge ref_clk);
    #1 q = rd_data;
    {ce, wr_en, rd_en, addr, wr_data} = {1'h1, 2'h0, ~a, ~d};
  endtask
endmodule

//--- bench/pll_divider_config_regs_test.sv
`timescale 1ns/1ps
module pll_divider_config_regs_test;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic ce, wr_en, rd_en, addr_hit, pfd_negative, pump_high_z, pump_force_source;
  logic pump_force_sink, pump_normal, loop_running, loop_async_pd, loop_sync_pd;
  logic loop_pd_unused;
  logic [1:0] pump_drive_select, loop_power_down;
  logic [2:0] pump_current_code;
  logic [9:0] addr;
  logic [7:0] wr_data, rd_data, q;
  logic [13:0] ref_divider;
  logic [5:0] swallow_count;
  logic [12:0] main_count;
  int n_errors = 0;
  int comparisons = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  pll_divider_config_regs u_dut (.*);
  host_model u_host (.*);
  task automatic chk(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // defaults seen by read-back and on the divider outputs
  task automatic t_reset;
    logic [7:0] rst [6] = '{8'h7d, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
    for (int i = 0; i < 6; i++) begin
      u_host.xfer(1'h0, 1'h1, 10'h010 + 10'(i), 8'h00, q);
      chk({u_host.hit, q}, {1'h1, rst[i]});
    end
    chk({pump_normal, loop_async_pd, ref_divider}, {2'h3, 14'h1});
    chk({pfd_negative, pump_current_code, pump_drive_select, loop_power_down}, 8'h7d);
    chk(swallow_count, 6'h00);
    chk(main_count, 13'h3);
    $display("reset test done");
  endtask
  // every pump and power-down code, decodes must be one-hot
  task automatic t_codes;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {1'h1, 3'(i), 2'(i), 2'(i)};
      u_host.xfer(1'h1, 1'h1, 10'h010, d, q);
      chk({pfd_negative, pump_current_code, pump_drive_select, loop_power_down}, d);
      chk({pump_high_z, pump_force_source, pump_force_sink, pump_normal}, 4'h8 >> i);
      chk({loop_running, loop_async_pd, loop_pd_unused, loop_sync_pd}, 4'h8 >> i);
    end
    $display("code test done");
  endtask
  // all-ones writes drop unused bits; gated and unmapped accesses do nothing
  task automatic t_fields;
    logic [7:0] msk [5] = '{8'hff, 8'h3f, 8'h3f, 8'hff, 8'h1f};
    for (int i = 0; i < 5; i++) begin
      u_host.xfer(1'h1, 1'h1, 10'h011 + 10'(i), 8'hff, q);
      u_host.xfer(1'h0, 1'h1, 10'h011 + 10'(i), 8'h00, q);
      chk({u_host.hit, q}, {1'h1, msk[i]});
    end
    chk({ref_divider, swallow_count}, {14'h3fff, 6'h3f});
    chk(main_count, 13'h1fff);
    u_host.xfer(1'h1, 1'h0, 10'h011, 8'h55, q);
    chk(ref_divider, 14'h3fff);
    u_host.xfer(1'h1, 1'h1, 10'h016, 8'h00, q);
    chk({ref_divider, main_count}, {14'h3fff, 13'h1fff});
    u_host.xfer(1'h0, 1'h1, 10'h016, 8'h00, q);
    chk({u_host.hit, q}, 9'h000);
    $display("field test done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'h1;
    t_reset;
    t_codes;
    t_fields;
    end_sim;
  end
  // the tests need under fifty cycles, so 5000 means a hang
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule
